/* logic/soag_pkg.sv */
// shared types and constants for segmented operand address generation
package soag_pkg;

   localparam int SEG_W = 7;
   localparam int OFS_W = 16;
   localparam int REG_W = 4;

   // addressing modes as decoded by the instruction decoder
   typedef enum logic [2:0] {
      SOAG_MODE_REG   = 3'b000,
      SOAG_MODE_LIT   = 3'b001,
      SOAG_MODE_PTR   = 3'b010,
      SOAG_MODE_ABS   = 3'b011,
      SOAG_MODE_TBL   = 3'b100,
      SOAG_MODE_PCREL = 3'b101,
      SOAG_MODE_PCON  = 3'b110,
      SOAG_MODE_PIDX  = 3'b111
   } soag_mode_t;

   // instruction class steering the address space
   typedef enum logic [1:0] {
      SOAG_CLS_MEM   = 2'b00,
      SOAG_CLS_IO    = 2'b01,
      SOAG_CLS_SPIO  = 2'b10,
      SOAG_CLS_JUMP  = 2'b11
   } soag_cls_t;

   // operand width picked by opcode in register mode
   typedef enum logic [1:0] {
      SOAG_W_BYTE = 2'b00,
      SOAG_W_WORD = 2'b01,
      SOAG_W_PAIR = 2'b10,
      SOAG_W_QUAD = 2'b11
   } soag_width_t;

   // address spaces driven towards the bus cycle logic
   typedef enum logic [2:0] {
      SOAG_SP_NONE  = 3'b000,
      SOAG_SP_PROG  = 3'b001,
      SOAG_SP_DATA  = 3'b010,
      SOAG_SP_STACK = 3'b011,
      SOAG_SP_IO    = 3'b100,
      SOAG_SP_SPIO  = 3'b101
   } soag_space_t;

   // the state machine of the generator
   typedef enum logic [1:0] {
      SOAG_ST_IDLE = 2'b00,
      SOAG_ST_ADDR = 2'b01
   } soag_state_t;

   localparam logic [REG_W-1:0] SOAG_REG_ZERO   = 4'h0;
   localparam logic [REG_W-1:0] SOAG_STACK_PAIR = 4'he;
   localparam logic [SEG_W-1:0] SOAG_SEG_RESET  = 7'h00;
   localparam logic [OFS_W-1:0] SOAG_OFS_RESET  = 16'h0000;
   localparam logic [6:0]       SOAG_SHORT_MAX  = 7'h7f;

   // segment field and short offset width inside the first address word
   localparam int SOAG_SEG_MSB = 14;
   localparam int SOAG_SEG_LSB = 8;
   localparam int SOAG_SHORT_W = 8;

   // segmented address: 7-bit segment beside a 16-bit offset
   typedef struct packed {
      logic [SEG_W-1:0] seg;
      logic [OFS_W-1:0] ofs;
   } soag_segaddr_t;

   // request from the instruction decoder
   typedef struct packed {
      soag_mode_t       mode;
      soag_cls_t        cls;
      soag_width_t      width;
      logic             is_load;
      logic             long_fmt;
      logic [REG_W-1:0] ptr_reg;
      logic [REG_W-1:0] idx_reg;
      logic [OFS_W-1:0] word1;
      logic [OFS_W-1:0] word2;
   } soag_req_t;

   // register file read values for the request
   typedef struct packed {
      soag_segaddr_t    ptr_pair;
      logic [OFS_W-1:0] ptr_word;
      logic [OFS_W-1:0] idx_word;
   } soag_regs_t;

   // answer towards the bus cycle logic
   typedef struct packed {
      soag_space_t      space;
      logic             stack;
      soag_segaddr_t    addr;
      logic             use_reg;
      soag_width_t      width;
      logic [REG_W-1:0] reg_sel;
      logic             pc_load;
      logic             illegal;
   } soag_ans_t;

endpackage

/* logic/soag_ofs_adder.sv */
// shared 16-bit offset adder with wraparound
`timescale 1ns/1ns
module soag_ofs_adder #(
   parameter int OFS_W = 16
) (
   // operands
   input  wire logic [OFS_W-1:0] a_i,
   input  wire logic [OFS_W-1:0] b_i,
   // result, carry dropped
   output wire logic [OFS_W-1:0] sum_o
);
   initial begin
      if (OFS_W < 1) begin
         $error("offset width must be positive");
      end
   end

   // carry out of the top bit is discarded on purpose
   wire logic [OFS_W:0] full_sum;
   assign full_sum = {1'b0, a_i} + {1'b0, b_i};
   assign sum_o    = full_sum[OFS_W-1:0];
endmodule

/* logic/soag_top.sv */
// operand effective-address generator, segmented variant
`timescale 1ns/1ns
// Function
// - register mode reads register, width by opcode
// - literal operands fetched from program space
// - pointer mode space follows instruction class
// - stack pair pointer signals stack access
// - word register for I/O, pair for memory
// - register zero never usable as pointer
// - absolute: I/O one word, memory short/long
// - absolute jump loads address into PC
// - table: index plus instruction offset, segment kept
// - table offset wraps, segment never changes
// - table operands always in data space
// - table base short/long; index not zero
// - relative: displacement plus next-instruction PC offset
// - relative operands in program space
// - constant displacement added to base pair offset
// - base stack pair signals stack access
// - index register added to base offset
// - base pair and index not zero
// - register bases always long segmented format
// - indexed-base and constant modes only for loads
module soag_top #(
   parameter int OFS_W = 16,
   parameter int SEG_W = 7
) (
   // clock and reset
   input  wire logic                clk_i,
   input  wire logic                resetn_i,
   // decoder request
   input  wire logic                req_valid_i,
   input  wire soag_pkg::soag_req_t req_i,
   input  wire soag_pkg::soag_regs_t regs_i,
   input  wire soag_pkg::soag_segaddr_t next_pc_i,
   output wire logic                req_ready_o,
   // answer to bus cycle logic
   output wire logic                ans_valid_o,
   input  wire logic                ans_ready_i,
   output soag_pkg::soag_ans_t      ans_o
);
   import soag_pkg::*;

   initial begin
      if (OFS_W != soag_pkg::OFS_W || SEG_W != soag_pkg::SEG_W) begin
         $error("only a 7-bit segment and 16-bit offset are supported");
      end
   end

   soag_state_t   state;
   soag_state_t   next_state;
   soag_ans_t     next_ans;

   // request decode
   wire logic     take;
   wire logic     io_cls;
   wire logic     ptr_zero;
   wire logic     idx_zero;
   wire logic     base_stack;
   wire logic     load_only;
   wire logic     bad_reg;
   assign take       = req_valid_i && (state == SOAG_ST_IDLE);
   assign io_cls     = (req_i.cls == SOAG_CLS_IO) || (req_i.cls == SOAG_CLS_SPIO);
   assign ptr_zero   = (req_i.ptr_reg == SOAG_REG_ZERO);
   assign idx_zero   = (req_i.idx_reg == SOAG_REG_ZERO);
   assign base_stack = (req_i.ptr_reg == SOAG_STACK_PAIR);
   assign load_only  = (req_i.mode == SOAG_MODE_PCON)
                       || (req_i.mode == SOAG_MODE_PIDX);

   // illegal register and non-load combinations per mode
   assign bad_reg =
      ((req_i.mode == SOAG_MODE_PTR) && ptr_zero) ||
      ((req_i.mode == SOAG_MODE_TBL) && idx_zero) ||
      ((req_i.mode == SOAG_MODE_PCON) && ptr_zero) ||
      ((req_i.mode == SOAG_MODE_PIDX) && (ptr_zero || idx_zero)) ||
      (load_only && !req_i.is_load);

   // absolute and table addresses from instruction words
   // short form: seg in word1[14:8], offset low byte in word1[7:0]
   // long form: seg in word1[14:8], offset is word2
   wire soag_segaddr_t inst_addr;
   wire logic [OFS_W-1:0] short_ofs;
   assign short_ofs       = {{(OFS_W-SOAG_SHORT_W){1'b0}}, req_i.word1[SOAG_SHORT_W-1:0]};
   assign inst_addr.seg   = req_i.word1[SOAG_SEG_MSB:SOAG_SEG_LSB];
   assign inst_addr.ofs   = req_i.long_fmt ? req_i.word2 : short_ofs;

   // shared adder operand selection
   wire logic [OFS_W-1:0] add_a;
   wire logic [OFS_W-1:0] add_b;
   wire logic [OFS_W-1:0] add_sum;
   assign add_a = (req_i.mode == SOAG_MODE_TBL)   ? inst_addr.ofs :
                  (req_i.mode == SOAG_MODE_PCREL) ? next_pc_i.ofs :
                  regs_i.ptr_pair.ofs;
   assign add_b = (req_i.mode == SOAG_MODE_TBL)   ? regs_i.idx_word :
                  (req_i.mode == SOAG_MODE_PCREL) ? req_i.word1 :
                  (req_i.mode == SOAG_MODE_PCON)  ? req_i.word1 :
                  regs_i.idx_word;

   soag_ofs_adder #(
      .OFS_W (OFS_W)
   ) u_adder (
      .a_i   (add_a),
      .b_i   (add_b),
      .sum_o (add_sum)
   );

   // pointer-in-register address and space
   wire soag_segaddr_t ptr_addr;
   wire soag_space_t   ptr_space;
   wire soag_space_t   mem_space;
   assign ptr_addr  = io_cls ? {SOAG_SEG_RESET, regs_i.ptr_word} : regs_i.ptr_pair;
   assign mem_space = base_stack ? SOAG_SP_STACK : SOAG_SP_DATA;
   assign ptr_space = (req_i.cls == SOAG_CLS_IO)   ? SOAG_SP_IO :
                      (req_i.cls == SOAG_CLS_SPIO) ? SOAG_SP_SPIO : mem_space;

   // absolute mode: I/O uses word1 only, jumps load the PC
   wire soag_segaddr_t abs_addr;
   wire soag_space_t   abs_space;
   assign abs_addr  = io_cls ? {SOAG_SEG_RESET, req_i.word1} : inst_addr;
   assign abs_space = (req_i.cls == SOAG_CLS_IO)   ? SOAG_SP_IO :
                      (req_i.cls == SOAG_CLS_SPIO) ? SOAG_SP_SPIO :
                      (req_i.cls == SOAG_CLS_JUMP) ? SOAG_SP_PROG : SOAG_SP_DATA;

   // answer formation per mode
   always_comb begin
      next_ans         = '0;
      next_ans.width   = req_i.width;
      next_ans.illegal = bad_reg;
      case (req_i.mode)
         SOAG_MODE_REG: begin
            next_ans.use_reg = 1'b1;
            next_ans.reg_sel = req_i.ptr_reg;
            next_ans.space   = SOAG_SP_NONE;
         end
         SOAG_MODE_LIT: begin
            next_ans.space = SOAG_SP_PROG;
            next_ans.addr  = next_pc_i;
         end
         SOAG_MODE_PTR: begin
            next_ans.space = ptr_space;
            next_ans.stack = !io_cls && base_stack;
            next_ans.addr  = ptr_addr;
         end
         SOAG_MODE_ABS: begin
            next_ans.space   = abs_space;
            next_ans.addr    = abs_addr;
            next_ans.pc_load = (req_i.cls == SOAG_CLS_JUMP);
         end
         SOAG_MODE_TBL: begin
            next_ans.space    = SOAG_SP_DATA;
            next_ans.addr.seg = inst_addr.seg;
            next_ans.addr.ofs = add_sum;
         end
         SOAG_MODE_PCREL: begin
            next_ans.space    = SOAG_SP_PROG;
            next_ans.addr.seg = next_pc_i.seg;
            next_ans.addr.ofs = add_sum;
         end
         SOAG_MODE_PCON,
         SOAG_MODE_PIDX: begin
            next_ans.space    = mem_space;
            next_ans.stack    = base_stack;
            next_ans.addr.seg = regs_i.ptr_pair.seg;
            next_ans.addr.ofs = add_sum;
         end
         default: begin
            next_ans.illegal = 1'b1;
         end
      endcase
   end

   // handshake state
   always_comb begin
      next_state = state;
      case (state)
         SOAG_ST_IDLE: begin
            if (req_valid_i) begin
               next_state = SOAG_ST_ADDR;
            end
         end
         SOAG_ST_ADDR: begin
            if (ans_ready_i) begin
               next_state = SOAG_ST_IDLE;
            end
         end
         default: begin
            next_state = SOAG_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state <= SOAG_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // answer register ahead of the bus address phase
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         ans_o <= '0;
      end else if (take) begin
         ans_o <= next_ans;
      end
   end

   assign req_ready_o = (state == SOAG_ST_IDLE);
   assign ans_valid_o = (state == SOAG_ST_ADDR);

   // checks
   table_space_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_TBL |=> ans_o.space == SOAG_SP_DATA)
      else $error("table operand not in data space");

   table_wrap_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_TBL |=>
      ans_o.addr.ofs == OFS_W'($past(inst_addr.ofs) + $past(regs_i.idx_word))
      && ans_o.addr.seg == $past(req_i.word1[SOAG_SEG_MSB:SOAG_SEG_LSB]))
      else $error("table offset or segment wrong");

   lit_prog_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_LIT |=> ans_o.space == SOAG_SP_PROG)
      else $error("literal not from program space");

   rel_calc_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_PCREL |=>
      ans_o.space == SOAG_SP_PROG
      && ans_o.addr.ofs == OFS_W'($past(next_pc_i.ofs) + $past(req_i.word1)))
      else $error("relative address wrong");

   ptr_stack_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_PTR && req_i.cls == SOAG_CLS_MEM |=>
      ans_o.stack == ($past(req_i.ptr_reg) == SOAG_STACK_PAIR))
      else $error("pointer stack indication wrong");

   ptr_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_PTR && req_i.ptr_reg == SOAG_REG_ZERO
      |=> ans_o.illegal)
      else $error("register zero accepted as pointer");

   base_seg_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && (req_i.mode == SOAG_MODE_PCON || req_i.mode == SOAG_MODE_PIDX) |=>
      ans_o.addr.seg == $past(regs_i.ptr_pair.seg))
      else $error("base segment altered");

   load_only_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_PIDX && !req_i.is_load |=> ans_o.illegal)
      else $error("indexed base allowed outside loads");

   jump_pc_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_ABS && req_i.cls == SOAG_CLS_JUMP |=>
      ans_o.pc_load && ans_valid_o)
      else $error("absolute jump does not load the PC");

   io_word_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_PTR && req_i.cls == SOAG_CLS_IO |=>
      ans_o.addr.ofs == $past(regs_i.ptr_word) && ans_o.space == SOAG_SP_IO)
      else $error("I/O pointer address wrong");

   reg_mode_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_REG |=>
      ans_o.use_reg && ans_o.space == SOAG_SP_NONE && ans_o.width == $past(req_i.width)
      && ans_o.reg_sel == $past(req_i.ptr_reg))
      else $error("register operand not selected");

   ptr_spio_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_PTR && req_i.cls == SOAG_CLS_SPIO |=>
      ans_o.space == SOAG_SP_SPIO && ans_o.addr.ofs == $past(regs_i.ptr_word))
      else $error("special I/O pointer access wrong");

   ptr_mem_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_PTR && req_i.cls == SOAG_CLS_MEM |=>
      ans_o.addr == $past(regs_i.ptr_pair)
      && ans_o.space == (ans_o.stack ? SOAG_SP_STACK : SOAG_SP_DATA))
      else $error("memory pointer address or space wrong");

   abs_short_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_ABS && req_i.cls == SOAG_CLS_MEM && !req_i.long_fmt |=>
      ans_o.addr.ofs == OFS_W'($past(req_i.word1[SOAG_SHORT_W-1:0]))
      && ans_o.space == SOAG_SP_DATA)
      else $error("short absolute address wrong");

   abs_long_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_ABS && req_i.cls == SOAG_CLS_MEM && req_i.long_fmt |=>
      ans_o.addr.ofs == $past(req_i.word2)
      && ans_o.addr.seg == $past(req_i.word1[SOAG_SEG_MSB:SOAG_SEG_LSB]))
      else $error("long absolute address wrong");

   abs_io_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_ABS && req_i.cls == SOAG_CLS_IO |=>
      ans_o.space == SOAG_SP_IO && ans_o.addr.ofs == $past(req_i.word1))
      else $error("I/O absolute address wrong");

   jump_prog_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_ABS && req_i.cls == SOAG_CLS_JUMP |=>
      ans_o.space == SOAG_SP_PROG
      && ans_o.addr.seg == $past(req_i.word1[SOAG_SEG_MSB:SOAG_SEG_LSB]))
      else $error("absolute jump target wrong");

   table_idx_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_TBL && req_i.idx_reg == SOAG_REG_ZERO |=> ans_o.illegal)
      else $error("register zero accepted as table index");

   rel_seg_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_PCREL |=> ans_o.addr.seg == $past(next_pc_i.seg))
      else $error("relative segment wrong");

   pcon_calc_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_PCON |=>
      ans_o.addr.ofs == OFS_W'($past(regs_i.ptr_pair.ofs) + $past(req_i.word1)))
      else $error("base plus displacement wrong");

   base_stack_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && (req_i.mode == SOAG_MODE_PCON || req_i.mode == SOAG_MODE_PIDX) |=>
      ans_o.stack == ($past(req_i.ptr_reg) == SOAG_STACK_PAIR)
      && ans_o.space == (ans_o.stack ? SOAG_SP_STACK : SOAG_SP_DATA))
      else $error("base stack indication wrong");

   pidx_calc_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_PIDX |=>
      ans_o.addr.ofs == OFS_W'($past(regs_i.ptr_pair.ofs) + $past(regs_i.idx_word)))
      else $error("base plus index wrong");

   pidx_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_PIDX
      && (req_i.ptr_reg == SOAG_REG_ZERO || req_i.idx_reg == SOAG_REG_ZERO) |=> ans_o.illegal)
      else $error("register zero accepted as base or index");

   pcon_load_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.mode == SOAG_MODE_PCON && !req_i.is_load |=> ans_o.illegal)
      else $error("base displacement allowed outside loads");

   ans_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ans_valid_o && !ans_ready_i |=> ans_valid_o && $stable(ans_o))
      else $error("answer changed before acceptance");
endmodule

/* verification/soag_bus_model.sv */
// bus cycle logic model: takes each answer after a chosen number of stall cycles
`timescale 1ns/1ns
module soag_bus_model (
   // clock and reset
   input  wire logic                clk_i,
   input  wire logic                resetn_i,
   // answer from the generator
   input  wire logic                ans_valid_i,
   input  wire soag_pkg::soag_ans_t ans_i,
   input  wire logic [3:0]          stall_i,
   output logic                     ans_ready_o,
   // last accepted answer
   output soag_pkg::soag_ans_t      last_o,
   output logic [7:0]               count_o
);
   import soag_pkg::*;
   logic [3:0] wait_cnt;
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         ans_ready_o <= 1'b0;
         wait_cnt    <= 4'h0;
         count_o     <= 8'h00;
         last_o      <= '0;
      end else if (ans_valid_i && ans_ready_o) begin
         ans_ready_o <= 1'b0;
         wait_cnt    <= 4'h0;
         last_o      <= ans_i;
         count_o     <= count_o + 8'h01;
      end else if (ans_valid_i) begin
         if (wait_cnt >= stall_i) begin
            ans_ready_o <= 1'b1;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule

/* verification/segmented_operand_address_gen_tb.sv */
// self-checking testbench of the operand address generator
`timescale 1ns/1ns
module segmented_operand_address_gen_tb;
   import soag_pkg::*;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic req_valid_i = 1'b0;
   soag_req_t req_i = '0;
   soag_regs_t regs_i = '0;
   soag_segaddr_t next_pc_i = '0;
   logic req_ready_o, ans_valid_o, ans_ready_i;
   soag_ans_t ans_o, got;
   logic [3:0] stall = 4'h0;
   logic [7:0] count;
   int n_fail = 0;
   int compares = 0;

   soag_top i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
      .req_i(req_i), .regs_i(regs_i), .next_pc_i(next_pc_i), .req_ready_o(req_ready_o),
      .ans_valid_o(ans_valid_o), .ans_ready_i(ans_ready_i), .ans_o(ans_o));
   soag_bus_model i_bus (.clk_i(clk_i), .resetn_i(resetn_i), .ans_valid_i(ans_valid_o),
      .ans_i(ans_o), .stall_i(stall), .ans_ready_o(ans_ready_i), .last_o(got),
      .count_o(count));

   initial begin
      forever #2 clk_i = ~clk_i;
   end

   task automatic finish_test;
      if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   function automatic soag_req_t mk(soag_mode_t m, soag_cls_t c, logic [3:0] p,
                                    logic [3:0] x, logic [15:0] w1, logic [15:0] w2,
                                    logic lf, logic ld);
      soag_req_t r;
      r = '{mode: m, cls: c, width: SOAG_W_WORD, is_load: ld, long_fmt: lf,
            ptr_reg: p, idx_reg: x, word1: w1, word2: w2};
      return r;
   endfunction

   // one request, held until taken, then wait for the bus model to accept the answer
   task automatic run(input soag_req_t r, input soag_regs_t g);
      int n;
      logic [7:0] c0;
      c0 = count;
      @(posedge clk_i);
      req_valid_i <= 1'b1;
      req_i <= r;
      regs_i <= g;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_i);
         if (req_ready_o === 1'b1) break;
      end
      req_valid_i <= 1'b0;
      for (n = 0; n < 40 && count === c0; n++) @(negedge clk_i);
      if (count === c0) begin
         n_fail++;
         $display("MISMATCH answer expected accepted seen timeout");
         finish_test();
      end
   endtask

   task automatic expect_addr(soag_space_t sp, logic stk, logic [6:0] sg, logic [15:0] of,
                              logic ill);
      chk("space", {29'h0, sp}, {29'h0, got.space});
      chk("stack", {31'h0, stk}, {31'h0, got.stack});
      chk("segment", {25'h0, sg}, {25'h0, got.addr.seg});
      chk("offset", {16'h0, of}, {16'h0, got.addr.ofs});
      chk("illegal", {31'h0, ill}, {31'h0, got.illegal});
   endtask

   task automatic sc_register;
      soag_req_t r;
      for (int w = 0; w < 4; w++) begin
         r = mk(SOAG_MODE_REG, SOAG_CLS_MEM, 4'h6, 4'h0, 16'h0000, 16'h0000, 1'b0, 1'b1);
         r.width = soag_width_t'(w);
         run(r, '0);
         chk("use_reg", 32'h1, {31'h0, got.use_reg});
         chk("width", w, {30'h0, got.width});
         chk("reg_sel", 32'h6, {28'h0, got.reg_sel});
      end
   endtask

   task automatic sc_literal_relative;
      @(posedge clk_i);
      next_pc_i <= '{seg: 7'd13, ofs: 16'h0206};
      run(mk(SOAG_MODE_LIT, SOAG_CLS_MEM, 4'h0, 4'h0, 16'h0055, 16'h0, 1'b0, 1'b1), '0);
      expect_addr(SOAG_SP_PROG, 1'b0, 7'd13, 16'h0206, 1'b0);
      run(mk(SOAG_MODE_PCREL, SOAG_CLS_MEM, 4'h0, 4'h0, 16'h0002, 16'h0, 1'b0, 1'b1), '0);
      expect_addr(SOAG_SP_PROG, 1'b0, 7'd13, 16'h0208, 1'b0);
      run(mk(SOAG_MODE_PCREL, SOAG_CLS_MEM, 4'h0, 4'h0, 16'hfdf8, 16'h0, 1'b0, 1'b1), '0);
      expect_addr(SOAG_SP_PROG, 1'b0, 7'd13, 16'hfffe, 1'b0);
   endtask

   task automatic sc_pointer;
      soag_regs_t g;
      g = '{ptr_pair: '{seg: 7'd20, ofs: 16'h170c}, ptr_word: 16'h0011, idx_word: 16'h0};
      run(mk(SOAG_MODE_PTR, SOAG_CLS_MEM, 4'h4, 4'h0, 16'h0, 16'h0, 1'b0, 1'b1), g);
      expect_addr(SOAG_SP_DATA, 1'b0, 7'd20, 16'h170c, 1'b0);
      run(mk(SOAG_MODE_PTR, SOAG_CLS_MEM, 4'he, 4'h0, 16'h0, 16'h0, 1'b0, 1'b1), g);
      expect_addr(SOAG_SP_STACK, 1'b1, 7'd20, 16'h170c, 1'b0);
      run(mk(SOAG_MODE_PTR, SOAG_CLS_IO, 4'he, 4'h0, 16'h0, 16'h0, 1'b0, 1'b1), g);
      expect_addr(SOAG_SP_IO, 1'b0, 7'd0, 16'h0011, 1'b0);
      run(mk(SOAG_MODE_PTR, SOAG_CLS_SPIO, 4'h1, 4'h0, 16'h0, 16'h0, 1'b0, 1'b1), g);
      expect_addr(SOAG_SP_SPIO, 1'b0, 7'd0, 16'h0011, 1'b0);
      run(mk(SOAG_MODE_PTR, SOAG_CLS_MEM, 4'h0, 4'h0, 16'h0, 16'h0, 1'b0, 1'b1), g);
      chk("illegal", 32'h1, {31'h0, got.illegal});
   endtask

   task automatic sc_absolute;
      run(mk(SOAG_MODE_ABS, SOAG_CLS_MEM, 4'h0, 4'h0, 16'h0f23, 16'h0, 1'b0, 1'b1), '0);
      expect_addr(SOAG_SP_DATA, 1'b0, 7'd15, 16'h0023, 1'b0);
      run(mk(SOAG_MODE_ABS, SOAG_CLS_MEM, 4'h0, 4'h0, 16'h8500, 16'h231a, 1'b1, 1'b1), '0);
      expect_addr(SOAG_SP_DATA, 1'b0, 7'd5, 16'h231a, 1'b0);
      run(mk(SOAG_MODE_ABS, SOAG_CLS_IO, 4'h0, 4'h0, 16'hc011, 16'h0, 1'b0, 1'b1), '0);
      expect_addr(SOAG_SP_IO, 1'b0, 7'd0, 16'hc011, 1'b0);
      run(mk(SOAG_MODE_ABS, SOAG_CLS_JUMP, 4'h0, 4'h0, 16'h8d00, 16'h4000, 1'b1, 1'b0), '0);
      expect_addr(SOAG_SP_PROG, 1'b0, 7'd13, 16'h4000, 1'b0);
      chk("pc_load", 32'h1, {31'h0, got.pc_load});
   endtask

   // reset while an answer is pending: generator comes back idle with a cleared answer
   task automatic sc_reset;
      @(posedge clk_i);
      req_valid_i <= 1'b1;
      req_i <= mk(SOAG_MODE_ABS, SOAG_CLS_JUMP, 4'h0, 4'h0, 16'h8d00, 16'h4000, 1'b1, 1'b0);
      @(posedge clk_i);
      req_valid_i <= 1'b0;
      resetn_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(negedge clk_i);
      chk("req_ready", 32'h1, {31'h0, req_ready_o});
      chk("ans_valid", 32'h0, {31'h0, ans_valid_o});
      chk("pc_load", 32'h0, {31'h0, ans_o.pc_load});
      chk("space", 32'h0, {29'h0, ans_o.space});
      chk("offset", 32'h0, {16'h0, ans_o.addr.ofs});
   endtask

   task automatic sc_table;
      soag_regs_t g;
      g = '{ptr_pair: '0, ptr_word: 16'h0, idx_word: 16'h01fe};
      run(mk(SOAG_MODE_TBL, SOAG_CLS_MEM, 4'h0, 4'h3, 16'h8500, 16'h231a, 1'b1, 1'b1), g);
      expect_addr(SOAG_SP_DATA, 1'b0, 7'd5, 16'h2518, 1'b0);
      g.idx_word = 16'h0003;
      run(mk(SOAG_MODE_TBL, SOAG_CLS_MEM, 4'h0, 4'hf, 16'h7ffe, 16'h0, 1'b0, 1'b1), g);
      expect_addr(SOAG_SP_DATA, 1'b0, 7'd127, 16'h0101, 1'b0);
      run(mk(SOAG_MODE_TBL, SOAG_CLS_MEM, 4'h0, 4'h1, 16'hfe00, 16'hfffe, 1'b1, 1'b1), g);
      expect_addr(SOAG_SP_DATA, 1'b0, 7'd126, 16'h0001, 1'b0);
      run(mk(SOAG_MODE_TBL, SOAG_CLS_MEM, 4'h0, 4'h0, 16'h8500, 16'h0, 1'b1, 1'b1), g);
      chk("illegal", 32'h1, {31'h0, got.illegal});
   endtask

   task automatic sc_base;
      soag_regs_t g;
      g = '{ptr_pair: '{seg: 7'd13, ofs: 16'h1502}, ptr_word: 16'h0, idx_word: 16'hfffe};
      stall = 4'h5;
      run(mk(SOAG_MODE_PIDX, SOAG_CLS_MEM, 4'h4, 4'h3, 16'h0, 16'h0, 1'b0, 1'b1), g);
      expect_addr(SOAG_SP_DATA, 1'b0, 7'd13, 16'h1500, 1'b0);
      stall = 4'h0;
      run(mk(SOAG_MODE_PIDX, SOAG_CLS_MEM, 4'he, 4'hf, 16'h0, 16'h0, 1'b0, 1'b1), g);
      expect_addr(SOAG_SP_STACK, 1'b1, 7'd13, 16'h1500, 1'b0);
      run(mk(SOAG_MODE_PIDX, SOAG_CLS_MEM, 4'h4, 4'h0, 16'h0, 16'h0, 1'b0, 1'b1), g);
      chk("illegal", 32'h1, {31'h0, got.illegal});
      run(mk(SOAG_MODE_PIDX, SOAG_CLS_MEM, 4'h0, 4'h3, 16'h0, 16'h0, 1'b0, 1'b1), g);
      chk("illegal", 32'h1, {31'h0, got.illegal});
      run(mk(SOAG_MODE_PCON, SOAG_CLS_MEM, 4'he, 4'h0, 16'hffe6, 16'h0, 1'b0, 1'b1), g);
      expect_addr(SOAG_SP_STACK, 1'b1, 7'd13, 16'h14e8, 1'b0);
      run(mk(SOAG_MODE_PCON, SOAG_CLS_MEM, 4'h2, 4'h0, 16'h0018, 16'h0, 1'b0, 1'b0), g);
      chk("illegal", 32'h1, {31'h0, got.illegal});
      run(mk(SOAG_MODE_PIDX, SOAG_CLS_MEM, 4'h2, 4'h3, 16'h0, 16'h0, 1'b0, 1'b0), g);
      chk("illegal", 32'h1, {31'h0, got.illegal});
   endtask

   initial begin
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      sc_register();
      sc_literal_relative();
      sc_pointer();
      sc_absolute();
      sc_reset();
      sc_table();
      sc_base();
      finish_test();
   end
endmodule
